/* rtl/phy_regs_pkg.sv */
// Register map, field layout and timing constants of the node register bank
package phy_regs_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned LONG_RESET_US = 166;
  localparam int unsigned LONG_RESET_CYC = LONG_RESET_US * (CLK_HZ / 1_000_000);

  // Internal 8-bit register indices
  localparam logic [3:0] IDX_NODE_IDENTITY_STATUS = 4'h0;
  localparam logic [3:0] IDX_ROOT_RESET_GAP_CONTROL = 4'h1;
  localparam logic [3:0] IDX_EXTENSION_PORT_COUNT = 4'h2;
  localparam logic [3:0] IDX_SPEED_DELAY_CAPABILITY = 4'h3;
  localparam logic [3:0] IDX_LINK_POWER_CONTENDER = 4'h4;
  localparam logic [3:0] IDX_INTERRUPT_FEATURE_CONTROL = 4'h5;
  localparam logic [3:0] IDX_RESERVED_SIX = 4'h6;
  localparam logic [3:0] IDX_PAGE_PORT_SELECTION = 4'h7;
  localparam logic [3:0] IDX_PAGED_FIRST = 4'h8;

  // APB byte offsets: internal registers at 4*index, extra block registers above
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h44;
  localparam logic [7:0] OFF_PAGE_STORE = 8'h48;
  localparam logic [7:0] OFF_EVENT_CTRL = 8'h4C;
  localparam logic [7:0] OFF_REG_SPAN = 8'h40;

  // Field positions in little-endian numbering (doc bit 0 = msb = bit 7)
  localparam int unsigned B_ROOT = 1;
  localparam int unsigned B_CPS = 0;
  localparam int unsigned B_HOLDOFF = 7;
  localparam int unsigned B_LONGRST = 6;
  localparam int unsigned B_PAGE_LO = 5;

  localparam logic [5:0] GAP_RESET = 6'h3F;
  localparam logic [2:0] EXT_VALUE = 3'h7;
  localparam logic [3:0] NUM_PORTS = 4'h2;
  localparam logic [2:0] SPEED_VALUE = 3'h2;
  localparam logic [3:0] DELAY_VALUE = 4'h0;
  localparam logic [2:0] PAGE_RSVD_LO = 3'h2;
  localparam logic [2:0] PAGE_RSVD_HI = 3'h6;

  // Interrupt status bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_SELFID = 0;
  localparam int unsigned IRQ_RSTDONE = 1;
  localparam int unsigned IRQ_CPSLOW = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RESET = 3'b100
  } rst_state_t;

  typedef struct packed {
    logic [7:0] pdata;
    logic [7:0] paddr;
    logic write;
    logic enable;
    logic sel;
  } apb_req_t;

  typedef struct packed {
    rst_state_t st;
    logic [31:0] prdata;
    logic [5:0] phys_id;
    logic root;
    logic holdoff;
    logic long_req;
    logic [5:0] gap;
    logic gap_written;
    logic [2:0] page;
    logic [3:0] port;
    logic [7:0] reg4;
    logic [7:0] reg5;
    logic [1:0][7:0][7:0] page_mem;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [16:0] cnt;
    logic cps_prev;
  } state_t;

endpackage

/* rtl/phy_register_map_base.sv */
// Node register bank of a two-port serial-bus physical layer, reached over APB
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
// Operation
// - Sixteen registers: eight base, eight paged
// - Paged window layout follows selected page
// - page_pick in register 7 picks page
// - Base fields independent of selected page
// - Reserved registers and fields read zero
// - Pages two through six read zero
// - Register 0 holds read-only node_phys_id
// - Register 0 status sent after self-id
// - root_flag cleared by bus reset, set if root
// - cable_power_ok mirrors cable power sense
// - root_holdoff requests root after next reset
// - root_holdoff cleared only by hardware reset (here a register 1 write of 0 also clears it)
// - long_reset_request starts 166 us bus reset
// - Finish ongoing traffic before bus reset
// - long_reset_request cleared by any reset
// - Gap count reloads 3Fh after two resets
module phy_register_map_base
  import phy_regs_pkg::*;
#(
  parameter int unsigned LONG_RESET_CYCLES = LONG_RESET_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cable_power_sense,
  input wire logic bus_reset_seen,
  input wire logic tree_id_root,
  input wire logic self_id_done,
  input wire logic [5:0] self_id_phys,
  input wire logic config_gap_valid,
  input wire logic [5:0] config_gap,
  input wire logic link_busy,
  output logic long_reset_drive,
  output logic root_contend,
  output logic reg0_status_pulse,
  output logic [7:0] reg0_status_data,
  output logic irq
);

  state_t s_q, s_d;
  logic cps_m_q, cps_q, busy_m_q, busy_q;
  logic bres_m_q, bres_q, root_m_q, root_q, sid_m_q, sid_q, cfg_m_q, cfg_q;
  logic bres_prev_q, sid_prev_q, cfg_prev_q;
  logic [7:0] reg0_dat_q;
  logic reg0_pls_q;
  logic [IRQ_W-1:0] ev;
  logic wr, rd, bres_rise, sid_rise, cfg_rise, rst_done;
  logic [3:0] ridx;
  logic [7:0] rbyte;
  logic [5:0] phys_m_q, phys_q, gap_m_q, gap_q;
  logic [2:0] page_wr;

  // Pins from the cable side are synchronised before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cps_m_q <= 1'b0;
      cps_q <= 1'b0;
      busy_m_q <= 1'b0;
      busy_q <= 1'b0;
      bres_m_q <= 1'b0;
      bres_q <= 1'b0;
      root_m_q <= 1'b0;
      root_q <= 1'b0;
      sid_m_q <= 1'b0;
      sid_q <= 1'b0;
      cfg_m_q <= 1'b0;
      cfg_q <= 1'b0;
      bres_prev_q <= 1'b0;
      sid_prev_q <= 1'b0;
      cfg_prev_q <= 1'b0;
    end else begin
      cps_m_q <= cable_power_sense;
      cps_q <= cps_m_q;
      busy_m_q <= link_busy;
      busy_q <= busy_m_q;
      bres_m_q <= bus_reset_seen;
      bres_q <= bres_m_q;
      root_m_q <= tree_id_root;
      root_q <= root_m_q;
      sid_m_q <= self_id_done;
      sid_q <= sid_m_q;
      cfg_m_q <= config_gap_valid;
      cfg_q <= cfg_m_q;
      bres_prev_q <= bres_q;
      sid_prev_q <= sid_q;
      cfg_prev_q <= cfg_q;
    end
  end

  // Data buses from the cable side; config_gap read on a synced strobe edge, self_id_phys also sampled each cycle for reg0_status_data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phys_m_q <= 6'h00;
      phys_q <= 6'h00;
      gap_m_q <= 6'h00;
      gap_q <= 6'h00;
    end else begin
      phys_m_q <= self_id_phys;
      phys_q <= phys_m_q;
      gap_m_q <= config_gap;
      gap_q <= gap_m_q;
    end
  end

  assign bres_rise = bres_q & ~bres_prev_q;
  assign sid_rise = sid_q & ~sid_prev_q;
  assign cfg_rise = cfg_q & ~cfg_prev_q;
  assign wr = psel & penable & pwrite;
  // Read captured in setup so data stands at the access edge
  assign rd = psel & ~penable & ~pwrite;
  assign ridx = paddr[5:2];
  assign page_wr = pwdata[7:B_PAGE_LO];
  assign rst_done = (s_q.st == ST_RESET) && (s_q.cnt == 17'(LONG_RESET_CYCLES - 1));

  // Read mux of the sixteen internal registers
  always_comb begin
    rbyte = 8'h00;
    if (ridx == IDX_NODE_IDENTITY_STATUS) begin
      rbyte = {s_q.phys_id, s_q.root, cps_q};
    end else if (ridx == IDX_ROOT_RESET_GAP_CONTROL) begin
      rbyte = {s_q.holdoff, s_q.long_req, s_q.gap};
    end else if (ridx == IDX_EXTENSION_PORT_COUNT) begin
      rbyte = {EXT_VALUE, 1'b0, NUM_PORTS};
    end else if (ridx == IDX_SPEED_DELAY_CAPABILITY) begin
      rbyte = {SPEED_VALUE, 1'b0, DELAY_VALUE};
    end else if (ridx == IDX_LINK_POWER_CONTENDER) begin
      rbyte = s_q.reg4;
    end else if (ridx == IDX_INTERRUPT_FEATURE_CONTROL) begin
      rbyte = s_q.reg5;
    end else if (ridx == IDX_RESERVED_SIX) begin
      rbyte = 8'h00;
    end else if (ridx == IDX_PAGE_PORT_SELECTION) begin
      rbyte = {s_q.page, 1'b0, s_q.port};
    end else if (s_q.page >= PAGE_RSVD_LO && s_q.page <= PAGE_RSVD_HI) begin
      rbyte = 8'h00;
    end else begin
      rbyte = s_q.page_mem[s_q.page[0]][ridx[2:0]];
    end
  end

  always_comb begin
    s_d = s_q;
    ev = '0;
    s_d.cps_prev = cps_q;
    ev[IRQ_CPSLOW] = s_q.cps_prev & ~cps_q;
    ev[IRQ_SELFID] = sid_rise;
    ev[IRQ_RSTDONE] = rst_done;
    if (rd && paddr < OFF_REG_SPAN) begin
      s_d.prdata = {24'h00_0000, rbyte};
    end else if (rd && paddr == OFF_IRQ_STATUS) begin
      s_d.prdata = {29'h0000_0000, s_q.irq_stat};
    end else if (rd && paddr == OFF_IRQ_MASK) begin
      s_d.prdata = {29'h0000_0000, s_q.irq_mask};
    end else if (rd && paddr == OFF_PAGE_STORE) begin
      s_d.prdata = {29'h0000_0000, s_q.page};
    end else if (rd && paddr == OFF_EVENT_CTRL) begin
      s_d.prdata = {29'h0000_0000, s_q.st};
    end else if (rd) begin
      s_d.prdata = 32'h0000_0000;
    end
    if (wr && paddr < OFF_REG_SPAN) begin
      if (ridx == IDX_ROOT_RESET_GAP_CONTROL) begin
        s_d.holdoff = pwdata[B_HOLDOFF];
        if (pwdata[B_LONGRST]) begin
          s_d.long_req = 1'b1;
        end
        s_d.gap = pwdata[5:0];
        s_d.gap_written = 1'b1;
      end else if (ridx == IDX_LINK_POWER_CONTENDER) begin
        s_d.reg4 = pwdata[7:0];
      end else if (ridx == IDX_INTERRUPT_FEATURE_CONTROL) begin
        s_d.reg5 = pwdata[7:0];
      end else if (ridx == IDX_PAGE_PORT_SELECTION) begin
        s_d.page = page_wr;
        s_d.port = pwdata[3:0];
      // Page seven shares page one storage
      end else if (ridx >= IDX_PAGED_FIRST
                   && (s_q.page < PAGE_RSVD_LO || s_q.page > PAGE_RSVD_HI)) begin
        s_d.page_mem[s_q.page[0]][ridx[2:0]] = pwdata[7:0];
      end
    end else if (wr && paddr == OFF_IRQ_MASK) begin
      s_d.irq_mask = pwdata[IRQ_W-1:0];
    end
    if (wr && paddr == OFF_IRQ_STATUS) begin
      s_d.irq_stat = s_q.irq_stat & ~pwdata[IRQ_W-1:0];
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    if (cfg_rise) begin
      s_d.gap = gap_q;
      s_d.gap_written = 1'b1;
    end
    if (sid_rise) begin
      s_d.phys_id = phys_q;
    end
    if (root_q) begin
      s_d.root = 1'b1;
    end
    case (s_q.st)
      ST_IDLE: begin
        if (s_q.long_req) begin
          s_d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!busy_q) begin
          s_d.st = ST_RESET;
          s_d.cnt = '0;
        end
      end
      ST_RESET: begin
        s_d.cnt = s_q.cnt + 17'h0_0001;
        if (rst_done) begin
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (bres_rise || rst_done) begin
      s_d.root = 1'b0;
      s_d.long_req = 1'b0;
      if (!s_q.gap_written) begin
        s_d.gap = GAP_RESET;
      end
      s_d.gap_written = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q.st <= ST_IDLE;
      s_q.prdata <= 32'h0000_0000;
      s_q.phys_id <= 6'h00;
      s_q.root <= 1'b0;
      s_q.holdoff <= 1'b0;
      s_q.long_req <= 1'b0;
      s_q.gap <= GAP_RESET;
      s_q.gap_written <= 1'b0;
      s_q.page <= 3'h0;
      s_q.port <= 4'h0;
      s_q.reg4 <= 8'h00;
      s_q.reg5 <= 8'h00;
      s_q.page_mem <= '0;
      s_q.irq_stat <= '0;
      s_q.irq_mask <= '0;
      s_q.cnt <= '0;
      s_q.cps_prev <= 1'b0;
      reg0_dat_q <= 8'h00;
      reg0_pls_q <= 1'b0;
    end else begin
      s_q <= s_d;
      reg0_pls_q <= sid_rise;
      reg0_dat_q <= {phys_q, s_q.root, cps_q};
    end
  end

  assign prdata = s_q.prdata;
  assign pready = psel & penable;
  assign pslverr = 1'b0;
  assign long_reset_drive = (s_q.st == ST_RESET);
  assign root_contend = s_q.holdoff;
  assign reg0_status_pulse = reg0_pls_q;
  assign reg0_status_data = reg0_dat_q;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

  // Long reset drive holds for at least eight cycles once started
  sequence rst_start_s;
    s_q.st == ST_WAIT && !busy_q;
  endsequence
  long_rst_len_a: assert property (@(posedge clk) disable iff (!rstn)
    rst_start_s |=> long_reset_drive [*8])
    else $error("long reset shorter than expected");
  busy_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.st == ST_WAIT && busy_q) |=> !long_reset_drive)
    else $error("bus reset started during traffic");
  req_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    bres_rise |=> !s_q.long_req)
    else $error("long reset request not cleared");
  root_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    (bres_rise && !root_q) |=> !s_q.root)
    else $error("root flag not cleared");
  holdoff_keep_a: assert property (@(posedge clk) disable iff (!rstn)
    (bres_rise && !wr) |=> $stable(s_q.holdoff))
    else $error("holdoff changed by bus reset");
  page_rsvd_a: assert property (@(posedge clk) disable iff (!rstn)
    (rd && paddr < OFF_REG_SPAN && ridx >= IDX_PAGED_FIRST
     && s_q.page >= PAGE_RSVD_LO && s_q.page <= PAGE_RSVD_HI) |=> prdata == 32'h0000_0000)
    else $error("reserved page read non-zero");
  cps_read_a: assert property (@(posedge clk) disable iff (!rstn)
    (rd && paddr == {2'b00, IDX_NODE_IDENTITY_STATUS, 2'b00}) |=> prdata[B_CPS] == $past(cps_q))
    else $error("power bit mismatch");
  reg0_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    sid_rise |=> reg0_status_pulse ##1 !reg0_status_pulse)
    else $error("register 0 status not sent");
  gap_reload_a: assert property (@(posedge clk) disable iff (!rstn)
    (bres_rise && !s_q.gap_written && !cfg_rise) |=> s_q.gap == GAP_RESET)
    else $error("gap count not reloaded");
  rsv6_a: assert property (@(posedge clk) disable iff (!rstn)
    (rd && paddr == {2'b00, IDX_RESERVED_SIX, 2'b00}) |=> prdata == 32'h0000_0000)
    else $error("reserved register non-zero");
  cps_event_a: assert property (@(posedge clk) disable iff (!rstn)
    ev[IRQ_CPSLOW] |=> s_q.irq_stat[IRQ_CPSLOW])
    else $error("power loss event not latched");
  selfid_event_a: assert property (@(posedge clk) disable iff (!rstn)
    sid_rise |=> s_q.irq_stat[IRQ_SELFID])
    else $error("self-id event not latched");
  done_event_a: assert property (@(posedge clk) disable iff (!rstn)
    rst_done |=> s_q.irq_stat[IRQ_RSTDONE])
    else $error("reset done event not latched");
  root_set_a: assert property (@(posedge clk) disable iff (!rstn)
    (root_q && !bres_rise && !rst_done) |=> s_q.root)
    else $error("root flag not set");
  req_set_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr && paddr == {2'b00, IDX_ROOT_RESET_GAP_CONTROL, 2'b00} && pwdata[B_LONGRST]
     && !bres_rise && !rst_done) |=> s_q.long_req)
    else $error("long reset request lost");
  wait_enter_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.st == ST_IDLE && s_q.long_req) |=> s_q.st == ST_WAIT)
    else $error("long reset request not taken");
  holdoff_set_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr && paddr == {2'b00, IDX_ROOT_RESET_GAP_CONTROL, 2'b00} && pwdata[B_HOLDOFF])
    |=> root_contend)
    else $error("root contention not requested");
  page_sel_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr && paddr == {2'b00, IDX_PAGE_PORT_SELECTION, 2'b00}) |=> s_q.page == $past(page_wr))
    else $error("page select not taken");
  phys_load_a: assert property (@(posedge clk) disable iff (!rstn)
    sid_rise |=> s_q.phys_id == $past(phys_q))
    else $error("node id not loaded");
  reg0_data_a: assert property (@(posedge clk) disable iff (!rstn)
    sid_rise |=> reg0_status_data == {$past(phys_q), $past(s_q.root), $past(cps_q)})
    else $error("register 0 status data wrong");
  gap_load_a: assert property (@(posedge clk) disable iff (!rstn)
    (cfg_rise && !bres_rise && !rst_done) |=> s_q.gap == $past(gap_q))
    else $error("configured gap count not loaded");
  gap_keep_a: assert property (@(posedge clk) disable iff (!rstn)
    (bres_rise && s_q.gap_written && !cfg_rise && !wr) |=> $stable(s_q.gap))
    else $error("gap count reloaded after a write");
  base_fixed_a: assert property (@(posedge clk) disable iff (!rstn)
    (rd && paddr == {2'b00, IDX_EXTENSION_PORT_COUNT, 2'b00})
    |=> prdata == {24'h00_0000, EXT_VALUE, 1'b0, NUM_PORTS})
    else $error("base register depends on page");

endmodule // phy_register_map_base

/* verification/link_ctrl_model.sv */
// Link-side register master model driving APB transfers
`timescale 1ns/1ps
module link_ctrl_model (
  input wire logic clk,
  input wire logic pready,
  input wire logic reg0_status_pulse,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // One APB transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask

  task automatic wait_status();
    while (reg0_status_pulse !== 1'b1) begin
      @(posedge clk);
    end
  endtask
endmodule // link_ctrl_model

/* verification/testbench.sv */
// Self-checking bench for the node register bank
`timescale 1ns/1ps
module testbench;
  import phy_regs_pkg::*;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
  } note_t;
  logic clk = 1'b0;
  logic rstn, psel, penable, pwrite, pready, pslverr, cable_power_sense, bus_reset_seen;
  logic tree_id_root, self_id_done, config_gap_valid, link_busy, long_reset_drive;
  logic root_contend, reg0_status_pulse, irq;
  logic [7:0] paddr, reg0_status_data, v, v0;
  logic [5:0] self_id_phys, config_gap;
  logic [31:0] pwdata, prdata, seed;
  note_t rdq[$];
  note_t nt;
  logic [7:0] stq[$];
  int bad_count = 0;
  int checks_done = 0;
  int n;

  always #10 clk = ~clk;

  phy_register_map_base #(.LONG_RESET_CYCLES(16)) dut_u (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cable_power_sense(cable_power_sense), .bus_reset_seen(bus_reset_seen),
    .tree_id_root(tree_id_root), .self_id_done(self_id_done), .self_id_phys(self_id_phys),
    .config_gap_valid(config_gap_valid), .config_gap(config_gap), .link_busy(link_busy),
    .long_reset_drive(long_reset_drive), .root_contend(root_contend),
    .reg0_status_pulse(reg0_status_pulse), .reg0_status_data(reg0_status_data), .irq(irq));

  link_ctrl_model link_u (.clk(clk), .pready(pready), .reg0_status_pulse(reg0_status_pulse),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    rdq.push_back('{e: {24'h00_0000, e}, m: {24'h00_0000, m}});
    link_u.xfer(1'b0, a, 8'h00);
  endtask

  task automatic bus_reset();
    @(posedge clk);
    bus_reset_seen <= 1'b1;
    repeat (4) @(posedge clk);
    bus_reset_seen <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // Read data is taken at the access edge
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      nt = rdq.pop_front();
      check(prdata & nt.m, nt.e);
    end
  end

  always @(posedge clk) begin
    if (reg0_status_pulse === 1'b1) begin
      check(32'(reg0_status_data), 32'(stq.pop_front()));
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial begin
    seed = 64261;
    rstn = 1'b0;
    cable_power_sense = 1'b1;
    {bus_reset_seen, tree_id_root, self_id_done, config_gap_valid, link_busy} = 5'h00;
    self_id_phys = 6'h00;
    config_gap = 6'h00;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    rd(8'h00, 8'h01, 8'hFF);
    rd(8'h04, {2'b00, GAP_RESET}, 8'hFF);
    rd(8'h08, 8'hE2, 8'hFF);
    rd(8'h0C, 8'h40, 8'hFF);
    rd(8'h18, 8'h00, 8'hFF);
    rd(8'h50, 8'h00, 8'hFF);
    check(32'(pslverr), 32'h0000_0000);
    for (int p = 0; p < 8; p++) begin
      v = 8'(rnd());
      if (p == 0) v0 = v;
      link_u.xfer(1'b1, 8'h1C, {3'(p), 5'h00});
      link_u.xfer(1'b1, 8'h24, v);
      rd(8'h24, (p < 2 || p == 7) ? v : 8'h00, 8'hFF);
      rd(8'h1C, {3'(p), 5'h00}, 8'hE0);
      rd(8'h08, 8'hE2, 8'hFF);
    end
    link_u.xfer(1'b1, 8'h1C, 8'h00);
    rd(8'h24, v0, 8'hFF);
    @(posedge clk);
    cable_power_sense <= 1'b0;
    repeat (6) @(posedge clk);
    rd(8'h00, 8'h00, 8'h01);
    check(32'(irq), 32'h0000_0000);
    link_u.xfer(1'b1, OFF_IRQ_MASK, 8'h04);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0000_0001);
    link_u.xfer(1'b1, OFF_IRQ_STATUS, 8'h04);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0000_0000);
    cable_power_sense <= 1'b1;
    link_u.xfer(1'b1, 8'h04, 8'h85);
    @(posedge clk);
    check(32'(root_contend), 32'h0000_0001);
    tree_id_root <= 1'b1;
    repeat (6) @(posedge clk);
    rd(8'h00, 8'h02, 8'h02);
    tree_id_root <= 1'b0;
    bus_reset();
    rd(8'h00, 8'h00, 8'h02);
    rd(8'h04, 8'h85, 8'hFF);
    check(32'(root_contend), 32'h0000_0001);
    bus_reset();
    rd(8'h04, 8'hBF, 8'hFF);
    v = 8'(rnd());
    config_gap <= v[5:0];
    config_gap_valid <= 1'b1;
    repeat (6) @(posedge clk);
    config_gap_valid <= 1'b0;
    rd(8'h04, {2'b00, v[5:0]}, 8'h3F);
    v = 8'(rnd());
    stq.push_back({v[5:0], 2'b01});
    self_id_phys <= v[5:0];
    self_id_done <= 1'b1;
    link_u.wait_status();
    self_id_done <= 1'b0;
    rd(8'h00, {v[5:0], 2'b01}, 8'hFF);
    link_busy <= 1'b1;
    link_u.xfer(1'b1, 8'h04, 8'h40);
    repeat (10) @(posedge clk);
    check(32'(long_reset_drive), 32'h0000_0000);
    link_busy <= 1'b0;
    for (n = 0; n < 100 && long_reset_drive !== 1'b1; n++) @(posedge clk);
    for (n = 0; n < 100 && long_reset_drive === 1'b1; n++) @(posedge clk);
    check(32'(n), 32'h0000_0010);
    repeat (6) @(posedge clk);
    rd(8'h04, 8'h00, 8'hC0);
    rd(OFF_IRQ_STATUS, 8'h03, 8'h07);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule // testbench
